/* File: alarm_warning_pkg.sv */
// constants, types and lookup for the alarm and warning manager
package alarm_warning_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_FAULTS = 10;
	localparam int NUM_PIN_FAULTS = 8;
	localparam int NUM_WARN = 8;
	localparam int HIST_DEPTH = 10;
	localparam logic [3:0] HIST_FULL = 4'hA;
	localparam logic [7:0] ALM_LINK_ERR = 8'h84;
	localparam logic [7:0] ALM_LINK_TMO = 8'h85;
	localparam logic [7:0] ALM_CONV = 8'h8E;
	localparam logic [7:0] ALM_SENSOR = 8'h28;
	localparam logic [7:0] ALM_INIT_SENSOR = 8'h42;
	localparam logic [7:0] ALM_ROTOR = 8'h43;
	localparam logic [7:0] ALM_MOTOR_TYPE = 8'h45;
	localparam logic [7:0] ALM_PERIPH = 8'h29;
	localparam logic [7:0] ALM_NVM = 8'h41;
	localparam logic [7:0] ALM_CPU = 8'hF0;
	localparam logic [3:0] BLINK_7 = 4'h7;
	localparam logic [3:0] BLINK_8 = 4'h8;
	localparam logic [3:0] BLINK_9 = 4'h9;
	localparam logic [3:0] BLINK_LIT = 4'hF;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ERR_LIMIT = 8'h04;
	localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
	localparam logic [7:0] ADDR_ALARM = 8'h0C;
	localparam logic [7:0] ADDR_WARN = 8'h10;
	localparam logic [7:0] ADDR_HIST_SEL = 8'h14;
	localparam logic [7:0] ADDR_HIST_DATA = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	localparam int CTRL_HIST_CLR_BIT = 0;
	localparam int ST_ALARM_BIT = 0;
	localparam int ST_WARN_BIT = 1;
	localparam int STAT_W = 2;
	localparam logic [7:0] ERR_LIMIT_RST = 8'h03;
	localparam logic [15:0] TIMEOUT_RST = 16'h0000;
	localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

	typedef struct packed {
		logic [7:0] code;
		logic clearable;
		logic excite_off;
		logic [3:0] blink;
	} alarm_info_t;

	typedef enum logic {ALM_IDLE = 1'b0, ALM_LATCHED = 1'b1} alarm_state_t;

	function automatic alarm_info_t alarm_lookup(input logic [3:0] idx);
		case (idx)
			4'h0: alarm_lookup = '{ALM_LINK_ERR, 1'b1, 1'b0, BLINK_7};
			4'h1: alarm_lookup = '{ALM_LINK_TMO, 1'b1, 1'b0, BLINK_7};
			4'h2: alarm_lookup = '{ALM_CONV, 1'b1, 1'b0, BLINK_7};
			4'h3: alarm_lookup = '{ALM_SENSOR, 1'b0, 1'b1, BLINK_8};
			4'h4: alarm_lookup = '{ALM_INIT_SENSOR, 1'b0, 1'b1, BLINK_8};
			4'h5: alarm_lookup = '{ALM_ROTOR, 1'b0, 1'b1, BLINK_8};
			4'h6: alarm_lookup = '{ALM_MOTOR_TYPE, 1'b0, 1'b1, BLINK_8};
			4'h7: alarm_lookup = '{ALM_PERIPH, 1'b0, 1'b1, BLINK_9};
			4'h8: alarm_lookup = '{ALM_NVM, 1'b0, 1'b1, BLINK_9};
			default: alarm_lookup = '{ALM_CPU, 1'b0, 1'b1, BLINK_LIT};
		endcase
	endfunction
endpackage

/* File: alarm_warning_manager.sv */
// alarm latch, warning output, warning history and AHB-Lite register slave
// Notes on behaviour
// - consecutive link errors reaching the limit raise 84h, clearable, excitation on, seven blinks
// - link timeout without good traffic raises 85h, clearable, excitation kept
// - converter alarm input raises 8Eh in the seven-blink group
// - running sensor fault raises 28h, eight blinks, not clearable, excitation off
// - sensor fault at power-up raises 42h, not clearable, excitation off
// - shaft moving at power-up raises 43h, not clearable, excitation off
// - unsupported motor raises 45h, eight blinks, not clearable, excitation off
// - processor peripheral fault 29h nine blinks; processor fault F0h lit steadily
// - corrupted stored data raises 41h, nine blinks, not clearable, excitation off
// - warning output rises with any warning condition; motor keeps running
// - warning output falls by itself once no condition remains
// - ten-entry history, newest first, oldest dropped when full
// - host reads history entries through the select and data registers
// - host erases history through the control register
// - history lives in flip-flops and is lost at reset
// - excitation-off alarms cut current and engage brake; others keep holding
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module alarm_warning_manager
	import alarm_warning_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
)(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic link_err_pulse,
	input wire logic link_good_pulse,
	input wire logic [NUM_PIN_FAULTS-1:0] fault_pins,
	input wire logic [NUM_WARN-1:0] warn_pins,
	input wire logic alarm_clear_input,
	output logic warning_output,
	output logic [3:0] fault_blink_indicator,
	output logic alarm_active,
	output logic excitation_en,
	output logic brake_engage,
	output logic irq
);
	localparam int SYNC_W = NUM_PIN_FAULTS + NUM_WARN + 1;
	logic [SYNC_W-1:0] sync1_r, sync2_r;
	logic clr_prev_r;
	logic [NUM_PIN_FAULTS-1:0] fault_s;
	logic [NUM_WARN-1:0] warn_s;
	logic clr_s, clr_rise;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			clr_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {alarm_clear_input, warn_pins, fault_pins};
			sync2_r <= sync1_r;
			clr_prev_r <= clr_s;
		end
	end
	assign fault_s = sync2_r[NUM_PIN_FAULTS-1:0];
	assign warn_s = sync2_r[NUM_PIN_FAULTS+NUM_WARN-1:NUM_PIN_FAULTS];
	assign clr_s = sync2_r[SYNC_W-1];
	assign clr_rise = clr_s & ~clr_prev_r;
	logic [7:0] err_limit_r, err_limit_nxt;
	logic [15:0] timeout_r, timeout_nxt;
	logic [3:0] hist_sel_r, hist_sel_nxt;
	logic [STAT_W-1:0] status_r, status_nxt, mask_r, mask_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic hist_clr;
	logic [15:0] div_r, div_nxt;
	logic [7:0] err_cnt_r, err_cnt_nxt;
	logic [15:0] tmo_cnt_r, tmo_cnt_nxt;
	logic tick, link_fault, tmo_fault, alarm_clear_evt;
	assign tick = (div_r == 16'(TICK_CYCLES_P - 1));
	assign link_fault = (err_limit_r != 8'h00) && (err_cnt_r >= err_limit_r);
	assign tmo_fault = (timeout_r != 16'h0000) && (tmo_cnt_r >= timeout_r);
	always_comb
	begin
		div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
		err_cnt_nxt = err_cnt_r;
		tmo_cnt_nxt = tmo_cnt_r;
		if (link_good_pulse || alarm_clear_evt)
			err_cnt_nxt = 8'h00;
		else if (link_err_pulse && err_cnt_r != 8'hFF)
			err_cnt_nxt = err_cnt_r + 8'h01;
		if (link_good_pulse || alarm_clear_evt)
			tmo_cnt_nxt = 16'h0000;
		else if (tick && tmo_cnt_r != 16'hFFFF)
			tmo_cnt_nxt = tmo_cnt_r + 16'h0001;
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_r <= 16'h0000;
			err_cnt_r <= 8'h00;
			tmo_cnt_r <= 16'h0000;
		end
		else
		begin
			div_r <= div_nxt;
			err_cnt_r <= err_cnt_nxt;
			tmo_cnt_r <= tmo_cnt_nxt;
		end
	end
	alarm_state_t alm_state_r, alm_state_nxt;
	alarm_info_t alm_info_r, alm_info_nxt, cand_info;
	logic [NUM_FAULTS-1:0] faults;
	logic [3:0] cand_idx;
	logic alarm_set;
	assign faults = {fault_s, tmo_fault, link_fault};
	assign alarm_clear_evt = (alm_state_r == ALM_LATCHED) && alm_info_r.clearable && clr_rise;
	always_comb
	begin
		cand_idx = 4'h0;
		// highest index is most severe and wins
		for (int i = 0; i < NUM_FAULTS; i++)
			if (faults[i])
				cand_idx = 4'(i);
		cand_info = alarm_lookup(cand_idx);
	end
	always_comb
	begin
		alm_state_nxt = alm_state_r;
		alm_info_nxt = alm_info_r;
		alarm_set = 1'b0;
		case (alm_state_r)
			ALM_IDLE:
			begin
				if (|faults)
				begin
					alm_state_nxt = ALM_LATCHED;
					alm_info_nxt = cand_info;
					alarm_set = 1'b1;
				end
			end
			ALM_LATCHED:
			begin
				if (alarm_clear_evt)
				begin
					alm_state_nxt = ALM_IDLE;
					alm_info_nxt = '0;
				end
			end
			default:
			begin
				alm_state_nxt = ALM_IDLE;
				alm_info_nxt = '0;
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alm_state_r <= ALM_IDLE;
			alm_info_r <= '0;
		end
		else
		begin
			alm_state_r <= alm_state_nxt;
			alm_info_r <= alm_info_nxt;
		end
	end
	assign alarm_active = (alm_state_r == ALM_LATCHED);
	assign fault_blink_indicator = alm_info_r.blink;
	assign excitation_en = !(alarm_active && alm_info_r.excite_off);
	assign brake_engage = alarm_active && alm_info_r.excite_off;
	logic warn_r, warn_nxt;
	logic [NUM_WARN-1:0] logged_r, logged_nxt, pend;
	logic [3:0] hist_r [HIST_DEPTH];
	logic [3:0] hist_nxt [HIST_DEPTH];
	logic [3:0] hist_cnt_r, hist_cnt_nxt, push_src;
	logic push;
	assign pend = warn_s & ~logged_r;
	assign push = |pend;
	always_comb
	begin
		warn_nxt = |warn_s;
		push_src = 4'h0;
		for (int i = NUM_WARN - 1; i >= 0; i--)
			if (pend[i])
				push_src = 4'(i);
		logged_nxt = logged_r & warn_s;
		if (push)
			logged_nxt[push_src[2:0]] = 1'b1;
		hist_nxt = hist_r;
		hist_cnt_nxt = hist_cnt_r;
		if (hist_clr)
		begin
			for (int i = 0; i < HIST_DEPTH; i++)
				hist_nxt[i] = 4'h0;
			hist_cnt_nxt = 4'h0;
		end
		// a push in the same cycle as an erase survives
		if (push)
		begin
			for (int i = HIST_DEPTH - 1; i > 0; i--)
				hist_nxt[i] = hist_clr ? 4'h0 : hist_r[i-1];
			hist_nxt[0] = push_src;
			if (hist_clr)
				hist_cnt_nxt = 4'h1;
			else if (hist_cnt_r != HIST_FULL)
				hist_cnt_nxt = hist_cnt_r + 4'h1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			warn_r <= 1'b0;
			logged_r <= '0;
			hist_cnt_r <= 4'h0;
			for (int i = 0; i < HIST_DEPTH; i++)
				hist_r[i] <= 4'h0;
		end
		else
		begin
			warn_r <= warn_nxt;
			logged_r <= logged_nxt;
			hist_cnt_r <= hist_cnt_nxt;
			hist_r <= hist_nxt;
		end
	end
	assign warning_output = warn_r;
	// AHB-Lite slave, zero wait states
	logic addr_ok;
	logic [7:0] a8;
	logic [31:0] rd_mux;
	assign addr_ok = hsel && htrans[1] && hready;
	assign a8 = haddr[7:0];
	assign hist_clr = wr_pend_r && wr_addr_r == ADDR_CTRL && hwdata[CTRL_HIST_CLR_BIT];
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (haddr[31:8] == 24'h000000)
			case (a8)
				ADDR_ERR_LIMIT: rd_mux = {24'h000000, err_limit_r};
				ADDR_TIMEOUT: rd_mux = {16'h0000, timeout_r};
				ADDR_ALARM: rd_mux = {16'h0000, alm_info_r.blink, 1'b0, alm_info_r.excite_off,
					alm_info_r.clearable, alarm_active, alm_info_r.code};
				ADDR_WARN: rd_mux = {12'h000, hist_cnt_r, 8'h00, warn_s};
				ADDR_HIST_SEL: rd_mux = {28'h0000000, hist_sel_r};
				ADDR_HIST_DATA: rd_mux = (hist_sel_r < hist_cnt_r) ? {28'h0000000, hist_r[hist_sel_r]}
					: 32'h0000_0000;
				ADDR_IRQ_STATUS: rd_mux = {30'h00000000, status_r};
				ADDR_IRQ_MASK: rd_mux = {30'h00000000, mask_r};
				default: rd_mux = 32'h0000_0000;
			endcase
	end
	always_comb
	begin
		wr_pend_nxt = addr_ok && hwrite;
		wr_addr_nxt = (haddr[31:8] == 24'h000000) ? a8 : 8'hFF;
		hrdata_nxt = (addr_ok && !hwrite) ? rd_mux : hrdata_r;
		err_limit_nxt = err_limit_r;
		timeout_nxt = timeout_r;
		hist_sel_nxt = hist_sel_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		if (wr_pend_r)
			case (wr_addr_r)
				ADDR_ERR_LIMIT: err_limit_nxt = hwdata[7:0];
				ADDR_TIMEOUT: timeout_nxt = hwdata[15:0];
				ADDR_HIST_SEL: hist_sel_nxt = hwdata[3:0];
				ADDR_IRQ_MASK: mask_nxt = hwdata[STAT_W-1:0];
				default: ;
			endcase
		if (addr_ok && !hwrite && haddr[31:8] == 24'h000000 && a8 == ADDR_IRQ_STATUS)
			status_nxt = '0;
		// set wins over read-clear
		if (alarm_set)
			status_nxt[ST_ALARM_BIT] = 1'b1;
		if (push)
			status_nxt[ST_WARN_BIT] = 1'b1;
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			err_limit_r <= ERR_LIMIT_RST;
			timeout_r <= TIMEOUT_RST;
			hist_sel_r <= 4'h0;
			mask_r <= MASK_RST;
			status_r <= '0;
		end
		else
		begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r <= hrdata_nxt;
			err_limit_r <= err_limit_nxt;
			timeout_r <= timeout_nxt;
			hist_sel_r <= hist_sel_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign irq = |(status_r & mask_r);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence err_reaches_limit;
		err_limit_r != 8'h00 && err_cnt_r == err_limit_r - 8'h01 && link_err_pulse && !link_good_pulse
			&& !alarm_clear_evt && alm_state_r == ALM_IDLE && !(|fault_s) && !tmo_fault;
	endsequence
	sequence link_alarm_latched;
		alarm_active && alm_info_r.code == ALM_LINK_ERR && excitation_en && fault_blink_indicator == BLINK_7;
	endsequence
	link_err_alarm_a: assert property (err_reaches_limit |=> ##1 link_alarm_latched)
		else $error("link error limit did not raise 84h");
	tmo_alarm_a: assert property (alm_state_r == ALM_IDLE && faults == 10'h002 |=> alarm_active
		&& alm_info_r.code == ALM_LINK_TMO && alm_info_r.clearable)
		else $error("timeout alarm wrong");
	cpu_alarm_a: assert property (alm_state_r == ALM_IDLE && fault_s[NUM_PIN_FAULTS-1] |=> alarm_active
		&& alm_info_r.code == ALM_CPU && fault_blink_indicator == BLINK_LIT)
		else $error("cpu fault not latched lit");
	nonclear_hold_a: assert property (alarm_active && !alm_info_r.clearable |=> alarm_active
		&& $stable(alm_info_r.code))
		else $error("non-clearable alarm released");
	excite_off_a: assert property (alarm_active && alm_info_r.excite_off |-> !excitation_en && brake_engage)
		else $error("excitation not cut");
	clear_ok_a: assert property (alarm_active && alm_info_r.clearable && clr_rise && !(|faults) |=> !alarm_active
		##1 !alarm_active)
		else $error("clearable alarm not released");
	warn_rise_a: assert property ($rose(|warn_s) |=> warning_output && excitation_en == $past(excitation_en))
		else $error("warning output late");
	warn_fall_a: assert property (!(|warn_s) [*2] |-> !warning_output)
		else $error("warning output stuck");
	hist_full_a: assert property (push && !hist_clr && hist_cnt_r == HIST_FULL |=> hist_cnt_r == HIST_FULL
		&& hist_r[0] == $past(push_src) && hist_r[HIST_DEPTH-1] == $past(hist_r[HIST_DEPTH-2]))
		else $error("full history push wrong");
	hist_clear_a: assert property (hist_clr && !push |=> hist_cnt_r == 4'h0 && hist_r[0] == 4'h0)
		else $error("history not erased");
	irq_set_a: assert property (alarm_set && mask_r[ST_ALARM_BIT] && !wr_pend_r |=> irq)
		else $error("alarm irq missing");
endmodule

/* File: alarm_host_model.sv */
// host model issuing single-word AHB-Lite transfers
`timescale 1ns/1ps
module alarm_host_model (
	input wire logic core_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		// released data lines show a changing pattern
		hwdata <= ~hwdata;
		@(posedge core_clk);
		while (hready !== 1'b1)
			@(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hready !== 1'b1)
			@(posedge core_clk);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
endmodule

/* File: test_alarm_warning_manager.sv */
// self-checking bench for the alarm and warning manager
`timescale 1ns/1ps
module test_alarm_warning_manager;
	import alarm_warning_pkg::*;
	typedef struct packed {
		logic [2:0] pin;
		logic [7:0] code;
		logic [3:0] blink;
		logic excite_off;
		logic clearable;
	} fault_row_t;
	fault_row_t rows [8] = '{'{3'h0, ALM_CONV, BLINK_7, 1'b0, 1'b1}, '{3'h1, ALM_SENSOR, BLINK_8, 1'b1, 1'b0},
		'{3'h2, ALM_INIT_SENSOR, BLINK_8, 1'b1, 1'b0}, '{3'h3, ALM_ROTOR, BLINK_8, 1'b1, 1'b0},
		'{3'h4, ALM_MOTOR_TYPE, BLINK_8, 1'b1, 1'b0}, '{3'h5, ALM_PERIPH, BLINK_9, 1'b1, 1'b0},
		'{3'h6, ALM_NVM, BLINK_9, 1'b1, 1'b0}, '{3'h7, ALM_CPU, BLINK_LIT, 1'b1, 1'b0}};
	logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, link_err_pulse, link_good_pulse, alarm_clear_input;
	logic warning_output, alarm_active, excitation_en, brake_engage, irq;
	logic [31:0] haddr, hwdata, hrdata, e;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] fault_pins, warn_pins;
	logic [3:0] fault_blink_indicator;
	int num_errors, checks_done, cycles;

	alarm_host_model host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	alarm_warning_manager #(.TICK_CYCLES_P(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_err_pulse(link_err_pulse),
		.link_good_pulse(link_good_pulse), .fault_pins(fault_pins), .warn_pins(warn_pins),
		.alarm_clear_input(alarm_clear_input), .warning_output(warning_output),
		.fault_blink_indicator(fault_blink_indicator), .alarm_active(alarm_active),
		.excitation_en(excitation_en), .brake_engage(brake_engage), .irq(irq));

	always #20 core_clk = !core_clk;

	task automatic tally_and_finish();
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		#1;
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		host.rd(a, q);
		check(q, exp);
		check(hresp, 32'h0);
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
	endtask

	task automatic cycles_wait(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wait_alarm(input logic v);
		int n;
		n = 0;
		while (alarm_active !== v && n < 40)
		begin
			@(posedge core_clk);
			n++;
		end
		check(alarm_active, v);
	endtask

	task automatic pulse_clear();
		alarm_clear_input <= 1'b1;
		cycles_wait(4);
		alarm_clear_input <= 1'b0;
		cycles_wait(6);
	endtask

	task automatic pulse_link(input logic bad);
		@(posedge core_clk);
		link_err_pulse <= bad;
		link_good_pulse <= !bad;
		@(posedge core_clk);
		link_err_pulse <= 1'b0;
		link_good_pulse <= 1'b0;
	endtask

	task automatic warn_pulse(input logic [7:0] p);
		warn_pins <= p;
		cycles_wait(5);
		check(warning_output, 32'h1);
		check(excitation_en, 32'h1);
		warn_pins <= 8'h00;
		cycles_wait(5);
		check(warning_output, 32'h0);
	endtask

	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		link_err_pulse = 1'b0;
		link_good_pulse = 1'b0;
		alarm_clear_input = 1'b0;
		fault_pins = 8'h00;
		warn_pins = 8'h00;
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		do_reset();
		check({alarm_active, warning_output, excitation_en, brake_engage, irq, fault_blink_indicator}, 32'h040);
		rd_chk(ADDR_ERR_LIMIT, 32'h3);
		rd_chk(ADDR_TIMEOUT, 32'h0);
		rd_chk(ADDR_IRQ_MASK, 32'h0);
		rd_chk(8'h40, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			do_reset();
			fault_pins <= 8'h01 << rows[i].pin;
			wait_alarm(1'b1);
			check(fault_blink_indicator, rows[i].blink);
			check({excitation_en, brake_engage}, {!rows[i].excite_off, rows[i].excite_off});
			fault_pins <= 8'h00;
			e = {16'h0, rows[i].blink, 1'b0, rows[i].excite_off, rows[i].clearable, 1'b1, rows[i].code};
			rd_chk(ADDR_ALARM, e);
			pulse_clear();
			wait_alarm(!rows[i].clearable);
		end
		do_reset();
		host.wr(ADDR_ERR_LIMIT, 32'h2);
		host.wr(ADDR_IRQ_MASK, 32'h1);
		pulse_link(1'b1);
		pulse_link(1'b0);
		pulse_link(1'b1);
		cycles_wait(4);
		check(alarm_active, 32'h0);
		pulse_link(1'b1);
		wait_alarm(1'b1);
		rd_chk(ADDR_ALARM, {16'h0, BLINK_7, 4'h3, ALM_LINK_ERR});
		check(excitation_en, 32'h1);
		check(irq, 32'h1);
		pulse_clear();
		wait_alarm(1'b0);
		pulse_link(1'b0);
		host.wr(ADDR_TIMEOUT, 32'h3);
		cycles_wait(3);
		check(alarm_active, 32'h0);
		wait_alarm(1'b1);
		rd_chk(ADDR_ALARM, {16'h0, BLINK_7, 4'h3, ALM_LINK_TMO});
		check(excitation_en, 32'h1);
		host.wr(ADDR_TIMEOUT, 32'h0);
		pulse_clear();
		wait_alarm(1'b0);
		host.wr(ADDR_IRQ_MASK, 32'h2);
		for (int k = 0; k < 12; k++)
			warn_pulse(8'h01 << (k % 8));
		check(irq, 32'h1);
		rd_chk(ADDR_WARN, 32'h000A0000);
		for (int s = 0; s < 11; s++)
		begin
			host.wr(ADDR_HIST_SEL, 32'(s));
			e = (s < 10) ? 32'((11 - s) % 8) : 32'h0;
			rd_chk(ADDR_HIST_DATA, e);
		end
		rd_chk(ADDR_IRQ_STATUS, 32'h3);
		check(irq, 32'h0);
		host.wr(ADDR_CTRL, 32'h1);
		rd_chk(ADDR_WARN, 32'h0);
		host.wr(ADDR_IRQ_MASK, 32'h0);
		warn_pulse(8'h10);
		check(irq, 32'h0);
		rd_chk(ADDR_IRQ_STATUS, 32'h2);
		rd_chk(ADDR_WARN, 32'h00010000);
		do_reset();
		rd_chk(ADDR_WARN, 32'h0);
		tally_and_finish();
	end
endmodule
